// ==== common/secf_pkg.sv ====
// Package for the serial channel extended feature block
package secf_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_RXPAR = 8'h0c;
   localparam logic [7:0] A_CLKMODE = 8'h10;
   localparam logic [7:0] A_TXPAR = 8'h14;
   localparam logic [7:0] A_SEVEN = 8'h1c;
   localparam logic [7:0] A_RXPAR_RB = 8'h24;
   localparam logic [7:0] A_MISCTR = 8'h28;
   localparam logic [7:0] A_MISCTR_RB = 8'h2c;
   localparam logic [7:0] A_MISCCTL = 8'h38;
   localparam logic [7:0] A_FSEL = 8'h3c;
   localparam logic [7:0] A_CTRL = 8'h40;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int FSEL_EXT = 0;
   localparam int EXT_RDEN = 6;
   localparam int EXT_TXLVL = 5;
   localparam int EXT_DTRT = 4;
   localparam int EXT_RXLVL = 3;
   localparam int EXT_ARTS = 2;
   localparam int EXT_AEOM = 1;
   localparam int EXT_AFLAG = 0;
   localparam logic [7:0] EXT_RST = 8'h20;
   localparam int TXP_DTR = 7;
   localparam int TXP_CRCP = 2;
   localparam int TXP_RTS = 1;
   localparam int MTR_CRCP = 7;
   localparam int MTR_ENC_HI = 6;
   localparam int MTR_ENC_LO = 5;
   localparam int MTR_MARK = 3;
   localparam int MCT_DTRREQ = 2;
   localparam int CTL_DMATX = 0;
   localparam int CTL_EOMCLR = 1;
   localparam logic [1:0] CM_SDLC = 2'b10;
   localparam logic [1:0] CM_SYNC = 2'b00;
   localparam logic [1:0] ENC_NRZI = 2'b01;
   localparam logic [2:0] TXF_DEPTH = 3'h4;
   localparam logic [3:0] RXF_HALF = 4'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int DEACT_PERIODS = 4;
   localparam logic [2:0] DEACT_CYC = 3'(DEACT_PERIODS);
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
      logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
   } secf_axi_req_s;
   typedef struct packed {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } secf_axi_rsp_s;
   typedef struct packed {
      logic [2:0] tx_cnt; logic [3:0] rx_cnt; logic tx_load; logic underrun;
      logic frame_act; logic flag_last; logic idle_reached; logic txd;
   } secf_core_s;
   typedef struct packed {
      logic tbe; logic rda; logic end_of_message_latch; logic crc_preset; logic [1:0] crc_preset_val;
      logic open_flag; logic crc_tail_en;
   } secf_ctl_s;
   typedef struct packed {
      logic w_req_n; logic dtr_req_n; logic rts_n; logic txd;
   } secf_pins_s;
endpackage : secf_pkg

// ==== hw/secf_channel.sv ====
// Extended feature logic of one serial channel with an AXI4-Lite register slave
// Overview of operation
// - Feature select bit reads back in bit zero
// - Select bit steers address seven writes to extended
// - Bit six opens readback of written registers
// - Bit five picks empty or top-byte TBE
// - Resets set bit five
// - DMA transmit request follows same FIFO level
// - Bit four sets DTR request deactivation timing
// - Bit three picks four-byte or one-byte RDA
// - Auto RTS release after closing flag bit
// - Otherwise RTS follows transmit parameter bit one
// - Bit one auto-clears END_OF_MESSAGE_LATCH, presets CRC
// - Bit zero sends opening flag automatically
// - SDLC keeps final two CRC bits
// - Other sync modes drop final two bits
// - NRZI mark idle forces TxD high
// - Clearing mark idle stops the forcing
// - Reset clears extended bits except five
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module secf_channel (
   input wire logic mclk,
   input wire logic nrst,
   input wire secf_pkg::secf_axi_req_s axi_req,
   output secf_pkg::secf_axi_rsp_s axi_rsp,
   input wire secf_pkg::secf_core_s core,
   output secf_pkg::secf_ctl_s ctl,
   input wire logic tx_clk,
   output secf_pkg::secf_pins_s pins
);
   import secf_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic aw_have; logic [7:0] aw_addr;
      logic w_have; logic [7:0] w_data; logic w_lane;
      secf_axi_rsp_s rsp;
      logic [7:0] rx_params; logic [7:0] clock_mode; logic [7:0] tx_params;
      logic [7:0] sync_char; logic [7:0] misc_tx_rx; logic [7:0] misc_ctrl;
      logic [7:0] fsel; logic [7:0] ext; logic [7:0] ctrl;
      logic end_of_message_latch; logic rts_hold; logic [2:0] deact_cnt; logic dtr_act;
      logic [2:0] txc;
      secf_ctl_s ctl;
      secf_pins_s pins;
   } secf_state_s;

   secf_state_s s_q;
   secf_state_s s_d;
   logic [1:0] rst_sync_q;
   logic rst_n;

   function automatic logic is_sdlc(input logic [7:0] cm);
      is_sdlc = (cm[5:4] == CM_SDLC);
   endfunction : is_sdlc

   function automatic logic is_sync(input logic [7:0] cm);
      is_sync = (cm[3:2] == CM_SYNC);
   endfunction : is_sync

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic do_wr;
   logic wr_ok;
   logic [7:0] rd_val;
   logic rd_ok;
   logic sdlc;
   logic tx_rise;
   logic tx_need;
   logic dma_tx;
   logic eom_cmd;
   logic auto_eom;
   logic rts_req;

   always_comb begin
      s_d = s_q;
      s_d.ctl.crc_preset = 1'b0;
      s_d.ctl.open_flag = 1'b0;
      sdlc = is_sdlc(s_q.clock_mode) && is_sync(s_q.clock_mode);
      eom_cmd = 1'b0;

      // Link clock: first stage feeds only the second
      s_d.txc = {s_q.txc[1:0], tx_clk};
      tx_rise = s_q.txc[1] && !s_q.txc[2];

      // Write channel: address and data accepted in either order
      if (axi_req.awvalid && s_q.rsp.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = axi_req.awaddr;
         s_d.rsp.awready = 1'b0;
      end
      if (axi_req.wvalid && s_q.rsp.wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = axi_req.wdata[7:0];
         s_d.w_lane = axi_req.wstrb[0];
         s_d.rsp.wready = 1'b0;
      end
      do_wr = s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid;
      wr_ok = 1'b1;
      if (do_wr) begin
         unique case (s_q.aw_addr)
            A_RXPAR: if (s_q.w_lane) s_d.rx_params = s_q.w_data;
            A_CLKMODE: if (s_q.w_lane) s_d.clock_mode = s_q.w_data;
            A_TXPAR: if (s_q.w_lane) s_d.tx_params = s_q.w_data;
            A_SEVEN: begin
               if (s_q.w_lane) begin
                  if (s_q.fsel[FSEL_EXT]) begin
                     s_d.ext = s_q.w_data;
                  end else begin
                     s_d.sync_char = s_q.w_data;
                  end
               end
            end
            A_MISCTR: if (s_q.w_lane) s_d.misc_tx_rx = s_q.w_data;
            A_MISCCTL: if (s_q.w_lane) s_d.misc_ctrl = s_q.w_data;
            A_FSEL: if (s_q.w_lane) s_d.fsel = s_q.w_data;
            A_CTRL: begin
               if (s_q.w_lane) begin
                  s_d.ctrl = s_q.w_data & 8'h01;
                  eom_cmd = s_q.w_data[CTL_EOMCLR];
               end
            end
            default: wr_ok = 1'b0;
         endcase
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = wr_ok ? RESP_OKAY : RESP_DECERR;
      end
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
         s_d.rsp.awready = 1'b1;
         s_d.rsp.wready = 1'b1;
      end

      // Read channel: one cycle from address to data
      rd_ok = 1'b1;
      unique case (axi_req.araddr)
         A_STATUS: rd_val = {s_q.end_of_message_latch, s_q.ctl.rda, s_q.ctl.tbe, core.rx_cnt[3:0], 1'b0};
         A_CLKMODE: rd_val = s_q.ext[EXT_RDEN] ? s_q.clock_mode : 8'h00;
         A_TXPAR: rd_val = s_q.ext[EXT_RDEN] ? s_q.tx_params : 8'h00;
         A_RXPAR_RB: rd_val = s_q.ext[EXT_RDEN] ? s_q.rx_params : 8'h00;
         A_MISCTR_RB: rd_val = s_q.ext[EXT_RDEN] ? s_q.misc_tx_rx : 8'h00;
         A_MISCCTL: rd_val = s_q.ext[EXT_RDEN] ? s_q.ext : 8'h00;
         A_FSEL: rd_val = s_q.fsel;
         A_CTRL: rd_val = {5'h00, core.tx_cnt};
         default: begin
            rd_val = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
      if (axi_req.arvalid && s_q.rsp.arready) begin
         s_d.rsp.arready = 1'b0;
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata = {24'h000000, rd_val};
         s_d.rsp.rresp = rd_ok ? RESP_OKAY : RESP_DECERR;
      end
      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
         s_d.rsp.arready = 1'b1;
      end

      // FIFO levels
      tx_need = s_q.ext[EXT_TXLVL] ? (core.tx_cnt == 3'h0) : (core.tx_cnt < TXF_DEPTH);
      s_d.ctl.tbe = tx_need;
      s_d.ctl.rda = s_q.ext[EXT_RXLVL] ? (core.rx_cnt >= RXF_HALF) : (core.rx_cnt != 4'h0);

      // DMA request pins
      dma_tx = s_q.ctrl[CTL_DMATX] && tx_need;
      s_d.pins.w_req_n = !dma_tx;
      if (s_q.misc_ctrl[MCT_DTRREQ]) begin
         if (dma_tx) begin
            s_d.dtr_act = 1'b1;
            s_d.deact_cnt = 3'h0;
         end else if (s_q.dtr_act) begin
            // Slow release gives the DMA controller time to see the edge
            if (s_q.ext[EXT_DTRT] || s_q.deact_cnt == DEACT_CYC - 3'h1) begin
               s_d.dtr_act = 1'b0;
               s_d.deact_cnt = 3'h0;
            end else begin
               s_d.deact_cnt = s_q.deact_cnt + 3'h1;
            end
         end
         s_d.pins.dtr_req_n = !s_d.dtr_act;
      end else begin
         s_d.dtr_act = 1'b0;
         s_d.deact_cnt = 3'h0;
         s_d.pins.dtr_req_n = !s_q.tx_params[TXP_DTR];
      end

      // Request to send
      rts_req = s_q.tx_params[TXP_RTS];
      if (!(sdlc && s_q.ext[EXT_ARTS])) begin
         s_d.rts_hold = 1'b0;
      end else if (rts_req && core.frame_act) begin
         s_d.rts_hold = 1'b1;
      end else if (tx_rise && core.flag_last) begin
         s_d.rts_hold = 1'b0;
      end
      s_d.pins.rts_n = !(rts_req || s_d.rts_hold);

      // End of message latch: a new underrun beats any clear
      auto_eom = s_q.ext[EXT_AEOM] && core.tx_load && s_q.end_of_message_latch;
      if (core.underrun) begin
         s_d.end_of_message_latch = 1'b1;
      end else if (eom_cmd || auto_eom) begin
         s_d.end_of_message_latch = 1'b0;
      end
      if (auto_eom) begin
         s_d.ctl.crc_preset = 1'b1;
      end
      s_d.ctl.crc_preset_val = {s_q.misc_tx_rx[MTR_CRCP], s_q.tx_params[TXP_CRCP]};
      s_d.ctl.end_of_message_latch = s_d.end_of_message_latch;

      // Opening flag on first load of an idle transmitter
      if (sdlc && s_q.ext[EXT_AFLAG] && core.tx_load && !core.frame_act) begin
         s_d.ctl.open_flag = 1'b1;
      end
      s_d.ctl.crc_tail_en = sdlc;

      // Line idles high so NRZI receivers see no stray transitions
      if (sdlc && s_q.misc_tx_rx[MTR_ENC_HI:MTR_ENC_LO] == ENC_NRZI
          && s_q.misc_tx_rx[MTR_MARK] && core.idle_reached) begin
         s_d.pins.txd = 1'b1;
      end else begin
         s_d.pins.txd = core.txd;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.rsp.awready <= 1'b1;
         s_q.rsp.wready <= 1'b1;
         s_q.rsp.arready <= 1'b1;
         s_q.ext <= EXT_RST;
         s_q.pins <= '1;
         s_q.pins.w_req_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign axi_rsp = s_q.rsp;
   assign ctl = s_q.ctl;
   assign pins = s_q.pins;
endmodule : secf_channel
`default_nettype wire

// ==== verification/secf_line_peer.sv ====
// Serial line peer that supplies the transmit clock
`timescale 1ns/10ps
`default_nettype none
module secf_line_peer (
   input wire logic run,
   output logic tx_clk
);
   // Clock stands low between frames; odd start keeps it out of step with mclk
   initial begin
      tx_clk = 1'b0;
      #137;
      forever begin
         #400;
         tx_clk = run & ~tx_clk;
      end
   end
endmodule : secf_line_peer
`default_nettype wire

// ==== verification/secf_channel_sva.sv ====
// Port checks for the serial channel
`timescale 1ns/10ps
`default_nettype none
module secf_channel_sva (
   input wire logic mclk,
   input wire logic nrst,
   input wire secf_pkg::secf_axi_req_s axi_req,
   input wire secf_pkg::secf_axi_rsp_s axi_rsp,
   input wire secf_pkg::secf_core_s core,
   input wire secf_pkg::secf_ctl_s ctl,
   input wire logic tx_clk,
   input wire secf_pkg::secf_pins_s pins
);
   import secf_pkg::*;
   logic [1:0] up_q;
   // Follows the two-flop reset release, so checks wait for the design
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (up_q != 2'h3);
   // ----
   // Bus steps
   // ----
   sequence s_wr_take;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sequence s_b_done;
      axi_rsp.bvalid && axi_req.bready;
   endsequence
   a_wr_lat: assert property (s_wr_take |-> ##2 axi_rsp.bvalid) else $error("bvalid late");
   a_b_release: assert property (s_b_done |=> !axi_rsp.bvalid ##[0:1] axi_rsp.awready)
      else $error("write not released");
   a_rd_lat: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("rvalid late");
   a_rdata_upper: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
      else $error("rdata upper bits set");
   a_tbe_empty: assert property (core.tx_cnt == 3'h0 |=> ctl.tbe) else $error("tbe low");
   a_rda_empty: assert property (core.rx_cnt == 4'h0 |=> !ctl.rda) else $error("rda high");
   a_rda_half: assert property (core.rx_cnt >= RXF_HALF |=> ctl.rda) else $error("rda low");
   a_eom_set: assert property ($rose(core.underrun) |=> ctl.end_of_message_latch) else $error("eom not set");
   a_txd_high: assert property (core.txd |=> pins.txd) else $error("txd not high");
   a_preset_load: assert property (ctl.crc_preset |-> $past(core.tx_load))
      else $error("crc preset without load");
   a_flag_load: assert property (ctl.open_flag |-> $past(core.tx_load))
      else $error("open flag without load");
endmodule : secf_channel_sva
bind secf_channel secf_channel_sva u_sva (.mclk(mclk), .nrst(nrst), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .core(core), .ctl(ctl), .tx_clk(tx_clk), .pins(pins));
`default_nettype wire

// ==== verification/secf_channel_test.sv ====
// Self-checking bench for the serial channel extended features
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module secf_channel_test;
   import secf_pkg::*;
   typedef struct packed {
      logic [7:0] ext; logic [2:0] tx; logic [3:0] rx; logic tbe; logic rda;
   } secf_row_s;
   secf_row_s rows [4] = '{'{8'h60, 3'h2, 4'h1, 1'b0, 1'b1}, '{8'h60, 3'h0, 4'h0, 1'b1, 1'b0},
      '{8'h48, 3'h2, 4'h3, 1'b1, 1'b0}, '{8'h4c, 3'h4, 4'h4, 1'b0, 1'b1}};
   logic mclk;
   logic nrst;
   logic tx_clk;
   secf_axi_req_s q;
   secf_axi_rsp_s r;
   secf_core_s c;
   secf_ctl_s ctl;
   secf_pins_s pins;
   logic [31:0] d;
   logic [1:0] rs;
   int errors;
   int checked;
   int cyc;
   secf_channel DUT (.mclk(mclk), .nrst(nrst), .axi_req(q), .axi_rsp(r), .core(c),
      .ctl(ctl), .tx_clk(tx_clk), .pins(pins));
   secf_line_peer u_peer (.run(c.frame_act), .tx_clk(tx_clk));
   // ----
   // Bus tasks and closing
   // ----
   task automatic stop_test();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      q.awaddr <= a;
      q.wdata <= {24'h0, v};
      q.wstrb <= 4'hf;
      q.awvalid <= 1'b1;
      q.wvalid <= 1'b1;
      q.bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (r.awready === 1'b1) q.awvalid <= 1'b0;
         if (r.wready === 1'b1) q.wvalid <= 1'b0;
      end while (r.bvalid !== 1'b1);
      rs = r.bresp;
      q.bready <= 1'b0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      q.araddr <= a;
      q.arvalid <= 1'b1;
      q.rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (r.arready === 1'b1) q.arvalid <= 1'b0;
      end while (r.rvalid !== 1'b1);
      d = r.rdata;
      rs = r.rresp;
      q.rready <= 1'b0;
      @(posedge mclk);
   endtask : rd
   // One-cycle load strobe; returns at the edge that shows the design's response
   task automatic pulse_load();
      c.tx_load <= 1'b1;
      @(posedge mclk);
      c.tx_load <= 1'b0;
      @(posedge mclk);
   endtask : pulse_load
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      nrst = 1'b0;
      q = '0;
      c = '0;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK(pins, 4'hf)
      `CHK(ctl.crc_tail_en, 1'b0)
      rd(A_FSEL);
      `CHK(d, 32'h0)
      wr(A_FSEL, 8'h01);
      `CHK(rs, RESP_OKAY)
      rd(A_FSEL);
      `CHK(d, 32'h1)
      c.tx_cnt <= 3'h2;
      c.rx_cnt <= 4'h1;
      repeat (2) @(posedge mclk);
      `CHK(ctl.tbe, 1'b0)
      `CHK(ctl.rda, 1'b1)
      wr(A_CTRL, 8'h01);
      foreach (rows[i]) begin
         wr(A_SEVEN, rows[i].ext);
         c.tx_cnt <= rows[i].tx;
         c.rx_cnt <= rows[i].rx;
         repeat (2) @(posedge mclk);
         rd(A_MISCCTL);
         `CHK(d[7:0], rows[i].ext)
         `CHK(ctl.tbe, rows[i].tbe)
         `CHK(ctl.rda, rows[i].rda)
         `CHK(pins.w_req_n, ~rows[i].tbe)
      end
      wr(A_FSEL, 8'h00);
      wr(A_SEVEN, 8'h00);
      rd(A_MISCCTL);
      `CHK(d[7:0], 8'h4c)
      rd(8'h80);
      `CHK(rs, RESP_DECERR)
      wr(8'h80, 8'h00);
      `CHK(rs, RESP_DECERR)
      wr(A_TXPAR, 8'h02);
      repeat (2) @(posedge mclk);
      `CHK(pins.rts_n, 1'b0)
      wr(A_TXPAR, 8'h00);
      repeat (2) @(posedge mclk);
      `CHK(pins.rts_n, 1'b1)
      wr(A_CLKMODE, 8'h20);
      wr(A_TXPAR, 8'h02);
      `CHK(ctl.crc_tail_en, 1'b1)
      c.frame_act <= 1'b1;
      wr(A_TXPAR, 8'h00);
      repeat (3) @(posedge mclk);
      `CHK(pins.rts_n, 1'b0)
      c.flag_last <= 1'b1;
      repeat (16) @(posedge mclk);
      `CHK(pins.rts_n, 1'b1)
      c.flag_last <= 1'b0;
      c.frame_act <= 1'b0;
      c.idle_reached <= 1'b1;
      wr(A_MISCTR, 8'h28);
      repeat (2) @(posedge mclk);
      `CHK(pins.txd, 1'b1)
      wr(A_MISCTR, 8'h20);
      repeat (2) @(posedge mclk);
      `CHK(pins.txd, 1'b0)
      c.underrun <= 1'b1;
      @(posedge mclk);
      c.underrun <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK(ctl.end_of_message_latch, 1'b1)
      wr(A_CTRL, 8'h03);
      `CHK(ctl.end_of_message_latch, 1'b0)
      // ----
      // Automatic end of message clear and opening flag
      // ----
      wr(A_FSEL, 8'h01);
      wr(A_SEVEN, 8'h4e);
      wr(A_TXPAR, 8'h04);
      wr(A_MISCTR, 8'ha0);
      `CHK(ctl.crc_preset_val, 2'h3)
      c.underrun <= 1'b1;
      @(posedge mclk);
      c.underrun <= 1'b0;
      @(posedge mclk);
      `CHK(ctl.end_of_message_latch, 1'b1)
      pulse_load();
      `CHK(ctl.crc_preset, 1'b1)
      `CHK(ctl.end_of_message_latch, 1'b0)
      `CHK(ctl.open_flag, 1'b0)
      @(posedge mclk);
      `CHK(ctl.crc_preset, 1'b0)
      wr(A_SEVEN, 8'h4f);
      pulse_load();
      `CHK(ctl.open_flag, 1'b1)
      `CHK(ctl.crc_preset, 1'b0)
      @(posedge mclk);
      `CHK(ctl.open_flag, 1'b0)
      // ----
      // Request pin release, slow and fast
      // ----
      wr(A_MISCCTL, 8'h04);
      c.tx_cnt <= 3'h3;
      repeat (2) @(posedge mclk);
      `CHK(pins.dtr_req_n, 1'b0)
      c.tx_cnt <= 3'h4;
      repeat (2) @(posedge mclk);
      `CHK(pins.w_req_n, 1'b1)
      `CHK(pins.dtr_req_n, 1'b0)
      repeat (2) @(posedge mclk);
      `CHK(pins.dtr_req_n, 1'b0)
      @(posedge mclk);
      `CHK(pins.dtr_req_n, 1'b1)
      wr(A_SEVEN, 8'h5f);
      c.tx_cnt <= 3'h3;
      repeat (2) @(posedge mclk);
      `CHK(pins.dtr_req_n, 1'b0)
      c.tx_cnt <= 3'h4;
      repeat (2) @(posedge mclk);
      `CHK(pins.dtr_req_n, 1'b1)
      // ----
      // Reset in mid-run restores the extended defaults
      // ----
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      c.tx_cnt <= 3'h2;
      c.rx_cnt <= 4'h1;
      repeat (4) @(posedge mclk);
      `CHK(ctl.tbe, 1'b0)
      `CHK(ctl.rda, 1'b1)
      `CHK(ctl.crc_tail_en, 1'b0)
      rd(A_MISCCTL);
      `CHK(d, 32'h0)
      stop_test();
   end
endmodule : secf_channel_test
`undef CHK
`default_nettype wire
